/* dv/core_bus_model.sv */
// Core side model: one nibble access per clock on the port bus.
// Assumes the bench clock and combinational read data from the ports.
`timescale 1ns/1ps
`default_nettype none

module core_bus_model
    import nibble_io_pkg::*;
(
    input  wire logic    clk_in,
    input  wire nibble_t rdata_in,
    output var  bank_t   bank_out,
    output var  logic    space_out,
    output var  addr_t   addr_out,
    output var  logic    wr_out,
    output var  nibble_t wdata_out
);
    initial
    begin
        bank_out  = 4'h0;
        space_out = 1'b0;
        addr_out  = 7'h00;
        wr_out    = 1'b0;
        wdata_out = 4'h0;
    end

    // Request held from a falling edge through the next rising edge
    task automatic put(input logic sp, input bank_t bk, input addr_t ad, input nibble_t d);
        @(negedge clk_in);
        space_out = sp;
        bank_out  = bk;
        addr_out  = ad;
        wdata_out = d;
        wr_out    = 1'b1;
    endtask : put

    // Released data lines toggle so stale values are never read as valid
    task automatic idle();
        @(negedge clk_in);
        wr_out    = 1'b0;
        wdata_out = ~wdata_out;
    endtask : idle

    // Read data is combinational; sampled mid-cycle, before the next edge
    task automatic get(input logic sp, input bank_t bk, input addr_t ad, output nibble_t d);
        idle();
        space_out = sp;
        bank_out  = bk;
        addr_out  = ad;
        #5 d = rdata_in;
    endtask : get
endmodule : core_bus_model

`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the three nibble I/O ports.
// Assumes the core model drives the bus; pins are resolved here from oe.
`timescale 1ns/1ps
`default_nettype none
`include "nibble_io_defs.svh"

module tb_top;
    import nibble_io_pkg::*;

    logic      clk;
    logic      rst_n;
    bank_t     bank;
    logic      space;
    addr_t     addr;
    logic      wr;
    nibble_t   wdata;
    wire [3:0] rdata;
    nibble_t   ext [3];
    wire [3:0] pout [3];
    wire [3:0] poe [3];
    wire [3:0] pin [3];
    wire [1:0] pu;
    wire [3:0] asel;
    wire [1:0] chan;
    int        err_count;
    int        checks_done;

    // ------------------------------------------------------------------
    // Clock, pins and instances
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    for (genvar i = 0; i < 3; i++)
    begin : g_pin
        assign pin[i] = (poe[i] & pout[i]) | (~poe[i] & ext[i]);
    end

    core_bus_model core (.clk_in(clk), .rdata_in(rdata), .bank_out(bank),
        .space_out(space), .addr_out(addr), .wr_out(wr), .wdata_out(wdata));

    nibble_io_ports dut (.ref_clk_in(clk), .rst_n_in(rst_n), .core_bank_in(bank),
        .core_rf_space_in(space), .core_addr_in(addr), .core_wr_in(wr),
        .core_wdata_in(wdata), .core_rdata_out(rdata),
        .first_port_pin_in(pin[0]), .first_port_pin_out(pout[0]),
        .first_port_pin_oe_out(poe[0]), .first_port_pullup_out(pu[0]),
        .second_port_pin_in(pin[1]), .second_port_pin_out(pout[1]),
        .second_port_pin_oe_out(poe[1]), .second_port_pullup_out(pu[1]),
        .third_port_pin_in(pin[2]), .third_port_pin_out(pout[2]),
        .third_port_pin_oe_out(poe[2]), .third_port_analog_select_out(asel),
        .converter_channel_out(chan));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic sp, input addr_t ad, input nibble_t d);
        core.put(sp, 4'h0, ad, d);
    endtask : wr_reg

    task automatic rd_chk(input logic sp, input addr_t ad, input nibble_t exp, input string what);
        nibble_t d;
        core.get(sp, 4'h0, ad, d);
        chk(d, exp, what);
    endtask : rd_chk

    task automatic settle();
        repeat (6) core.idle();
    endtask : settle

    task automatic chk_clear();
        for (int i = 0; i < 3; i++)
        begin
            chk(pout[i], 4'h0, "latch clear");
            chk(poe[i], 4'h0, "dir clear");
        end
        chk({2'h0, pu}, 4'h0, "pullup clear");
        chk(asel, 4'h0, "analog clear");
        chk({2'h0, chan}, 4'h0, "channel clear");
    endtask : chk_clear

    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // Hang guard: far beyond the length of the sequence below
    initial
    begin
        #200000;
        err_count++;
        $display("Error at %0t: run limit reached", $time);
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        err_count   = 0;
        checks_done = 0;
        rst_n       = 1'b0;
        ext         = '{4'h0, 4'h0, 4'h0};
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk_clear();
        rd_chk(1'b1, `NIO_RF_PULLUP, 4'h0, "rf pullup");
        rd_chk(1'b1, `NIO_RF_ANALOG_SEL, 4'h0, "rf analog");
        rd_chk(1'b1, `NIO_RF_THIRD_DIR, 4'h0, "rf third dir");
        rd_chk(1'b1, `NIO_RF_CHANNEL, 4'h0, "rf channel");
        rd_chk(1'b1, `NIO_RF_GROUP_DIR, 4'h0, "rf group dir");
        $display("Test reset done");

        for (int p = 0; p < 2; p++)
        begin
            ext[p] = 4'h9;
            settle();
            wr_reg(1'b0, `NIO_ADDR_FIRST_PORT + 7'(p), 4'h6);
            core.idle();
            chk(pout[p], 4'h6, "latch in input mode");
            chk(poe[p], 4'h0, "still input");
            rd_chk(1'b0, `NIO_ADDR_FIRST_PORT + 7'(p), 4'h9, "pin read");
            wr_reg(1'b1, `NIO_RF_GROUP_DIR, 4'h1 << p);
            core.idle();
            chk(poe[p], 4'hf, "group output");
            chk(poe[1 - p], 4'h0, "other group input");
            chk(pin[p], 4'h6, "latch on pins");
            rd_chk(1'b0, `NIO_ADDR_FIRST_PORT + 7'(p), 4'h6, "latch read");
            wr_reg(1'b1, `NIO_RF_PULLUP, 4'h1 << p);
            core.idle();
            chk({3'h0, pu[p]}, 4'h1, "pullup on");
            chk({3'h0, pu[1 - p]}, 4'h0, "other pullup off");
            wr_reg(1'b1, `NIO_RF_GROUP_DIR, 4'h0);
            wr_reg(1'b1, `NIO_RF_PULLUP, 4'h0);
            ext[p] = 4'h0;
        end
        $display("Test group ports done");

        // Bit 0 is analog with output on, the case software should avoid
        // Direction goes last so two cycles without a register-file write follow it
        wr_reg(1'b1, `NIO_RF_ANALOG_SEL, 4'h5);
        wr_reg(1'b1, `NIO_RF_THIRD_DIR, 4'h3);
        wr_reg(1'b0, `NIO_ADDR_THIRD_PORT, 4'h0);
        ext[2] = 4'hf;
        settle();
        chk(poe[2], 4'h3, "bit direction");
        chk(asel, 4'h5, "analog select");
        rd_chk(1'b0, `NIO_ADDR_THIRD_PORT, 4'h8, "mixed read pins");
        wr_reg(1'b0, `NIO_ADDR_THIRD_PORT, 4'hf);
        ext[2] = 4'h0;
        settle();
        chk(pout[2], 4'hf, "third latch");
        rd_chk(1'b0, `NIO_ADDR_THIRD_PORT, 4'h7, "mixed read latch");
        $display("Test third port done");

        wr_reg(1'b1, `NIO_RF_CHANNEL, 4'hf);
        core.idle();
        chk({2'h0, chan}, 4'h3, "channel field");
        rd_chk(1'b1, `NIO_RF_CHANNEL, 4'h3, "channel read");
        wr_reg(1'b1, `NIO_RF_CHANNEL, 4'h6);
        core.idle();
        chk({2'h0, chan}, 4'h2, "channel two");
        core.put(1'b0, 4'h1, `NIO_ADDR_FIRST_PORT, 4'hf);
        core.idle();
        chk(pout[0], 4'h6, "other bank ignored");
        rd_chk(1'b0, 7'h73, 4'h0, "unmapped read");
        $display("Test channel and decode done");

        @(negedge clk);
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        chk_clear();
        rst_n = 1'b1;
        $display("Test second reset done");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire

/* hdl/nibble_io_defs.svh */
// Offsets, field positions and reset values for the nibble I/O ports.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef NIBBLE_IO_DEFS_SVH
`define NIBBLE_IO_DEFS_SVH

// ----------------------------------------------------------------------------
// Data memory bank zero
// ----------------------------------------------------------------------------
`define NIO_BANK_ZERO          4'h0
`define NIO_ADDR_FIRST_PORT    7'h70
`define NIO_ADDR_SECOND_PORT   7'h71
`define NIO_ADDR_THIRD_PORT    7'h72

// ----------------------------------------------------------------------------
// Register file
// ----------------------------------------------------------------------------
`define NIO_RF_PULLUP          7'h0c
`define NIO_RF_ANALOG_SEL      7'h1b
`define NIO_RF_THIRD_DIR       7'h1c
`define NIO_RF_CHANNEL         7'h22
`define NIO_RF_GROUP_DIR       7'h2c

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define NIO_BIT_FIRST_PORT     0
`define NIO_BIT_SECOND_PORT    1
`define NIO_RST_NIBBLE         4'h0
`define NIO_RST_GROUP          2'h0
`define NIO_RST_CHANNEL        2'h0

`endif

/* hdl/nibble_io_pkg.sv */
// Types shared by the nibble I/O port top, the core bus model and the bench.
// Assumes the constants header is on the include path.
`include "nibble_io_defs.svh"

package nibble_io_pkg;

    typedef logic [3:0] nibble_t;
    typedef logic [6:0] addr_t;
    typedef logic [3:0] bank_t;
    typedef logic [1:0] group_t;
    typedef logic [1:0] channel_t;

endpackage : nibble_io_pkg

/* hdl/nibble_io_ports.sv */
// Top of the three nibble I/O ports with analog pin select.
// Assumes a CPU core giving bank, address, space, write strobe and data per cycle.
`timescale 1ns/1ps
`default_nettype none

`include "nibble_io_defs.svh"

// Contract
// - First port latch decoded at bank zero address 70H.
// - Register-file 2CH bit 0 sets all first-port pins input or output.
// - Group port read gives pins in input mode, latch in output mode.
// - Group port writes always load the latch, even in input mode.
// - Register-file 0CH bit 0 enables first-port pull-ups.
// - Reset clears first-port direction, pull-up and latch.
// - Second port latch decoded at bank zero address 71H.
// - Register-file 2CH bit 1 sets all second-port pins input or output.
// - Register-file 0CH bit 1 enables second-port pull-ups.
// - Reset clears second-port direction, pull-up and latch.
// - Third port latch decoded at bank zero address 72H.
// - Register-file 1CH bit n sets third-port pin n direction.
// - Register-file 1BH bit n routes third-port pin n to analog input.
// - Third-port read gives pin only for digital input bits, else latch.
// - Third-port writes load the latch in every mode.
// - Register-file 22H bits 1 and 0 select converter channel.
// - Reset clears third-port direction, analog select, channel and latch.
module nibble_io_ports (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    input  wire nibble_io_pkg::bank_t core_bank_in,
    input  wire logic                 core_rf_space_in,
    input  wire nibble_io_pkg::addr_t core_addr_in,
    input  wire logic                 core_wr_in,
    input  wire nibble_io_pkg::nibble_t core_wdata_in,
    output logic [3:0]                core_rdata_out,
    input  wire nibble_io_pkg::nibble_t first_port_pin_in,
    output logic [3:0]                first_port_pin_out,
    output logic [3:0]                first_port_pin_oe_out,
    output logic                      first_port_pullup_out,
    input  wire nibble_io_pkg::nibble_t second_port_pin_in,
    output logic [3:0]                second_port_pin_out,
    output logic [3:0]                second_port_pin_oe_out,
    output logic                      second_port_pullup_out,
    input  wire nibble_io_pkg::nibble_t third_port_pin_in,
    output logic [3:0]                third_port_pin_out,
    output logic [3:0]                third_port_pin_oe_out,
    output logic [3:0]                third_port_analog_select_out,
    output logic [1:0]                converter_channel_out
);

    import nibble_io_pkg::*;

    group_t   group_dir_q;
    group_t   group_dir_d;
    group_t   pullup_q;
    group_t   pullup_d;
    nibble_t  third_dir_q;
    nibble_t  third_dir_d;
    nibble_t  analog_sel_q;
    nibble_t  analog_sel_d;
    channel_t channel_q;
    channel_t channel_d;

    logic     mem_hit;
    logic     rf_hit;
    logic     wr_mem;
    logic     wr_rf;

    port_slice_if #(.WIDTH(4)) first_if ();
    port_slice_if #(.WIDTH(4)) second_if ();
    port_slice_if #(.WIDTH(4)) third_if ();

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // The core names its space explicitly so register-file and data memory
    // addresses never alias each other.
    assign mem_hit = !core_rf_space_in && (core_bank_in == `NIO_BANK_ZERO);
    assign rf_hit  = core_rf_space_in;
    assign wr_mem  = mem_hit && core_wr_in;
    assign wr_rf   = rf_hit && core_wr_in;

    assign first_if.wr_stb  = wr_mem && (core_addr_in == `NIO_ADDR_FIRST_PORT);
    assign second_if.wr_stb = wr_mem && (core_addr_in == `NIO_ADDR_SECOND_PORT);
    assign third_if.wr_stb  = wr_mem && (core_addr_in == `NIO_ADDR_THIRD_PORT);
    assign first_if.wr_data  = core_wdata_in;
    assign second_if.wr_data = core_wdata_in;
    assign third_if.wr_data  = core_wdata_in;

    // ------------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------------
    always_comb
    begin
        group_dir_d  = group_dir_q;
        pullup_d     = pullup_q;
        third_dir_d  = third_dir_q;
        analog_sel_d = analog_sel_q;
        channel_d    = channel_q;
        if (wr_rf)
        begin
            case (core_addr_in)
                `NIO_RF_GROUP_DIR:  group_dir_d  = core_wdata_in[1:0];
                `NIO_RF_PULLUP:     pullup_d     = core_wdata_in[1:0];
                `NIO_RF_THIRD_DIR:  third_dir_d  = core_wdata_in;
                `NIO_RF_ANALOG_SEL: analog_sel_d = core_wdata_in;
                `NIO_RF_CHANNEL:    channel_d    = core_wdata_in[1:0];
                default:            group_dir_d  = group_dir_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            group_dir_q  <= `NIO_RST_GROUP;
            pullup_q     <= `NIO_RST_GROUP;
            third_dir_q  <= `NIO_RST_NIBBLE;
            analog_sel_q <= `NIO_RST_NIBBLE;
            channel_q    <= `NIO_RST_CHANNEL;
        end
        else
        begin
            group_dir_q  <= group_dir_d;
            pullup_q     <= pullup_d;
            third_dir_q  <= third_dir_d;
            analog_sel_q <= analog_sel_d;
            channel_q    <= channel_d;
        end
    end

    // ------------------------------------------------------------------------
    // Port slices
    // ------------------------------------------------------------------------
    assign first_if.dir         = {4{group_dir_q[`NIO_BIT_FIRST_PORT]}};
    assign second_if.dir        = {4{group_dir_q[`NIO_BIT_SECOND_PORT]}};
    assign third_if.dir         = third_dir_q;
    assign first_if.analog_sel  = 4'h0;
    assign second_if.analog_sel = 4'h0;
    assign third_if.analog_sel  = analog_sel_q;
    assign first_if.pin_raw     = first_port_pin_in;
    assign second_if.pin_raw    = second_port_pin_in;
    assign third_if.pin_raw     = third_port_pin_in;

    nibble_port_slice #(.WIDTH(4)) first_slice (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .io         (first_if.slice)
    );

    nibble_port_slice #(.WIDTH(4)) second_slice (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .io         (second_if.slice)
    );

    nibble_port_slice #(.WIDTH(4)) third_slice (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .io         (third_if.slice)
    );

    // ------------------------------------------------------------------------
    // Pins and outputs
    // ------------------------------------------------------------------------
    // Latches drive the pins at all times; the enables decide who wins.
    // An analog pin left in output mode still drives, which corrupts the
    // sampled level, so software must keep its direction at zero.
    assign first_port_pin_out           = first_if.latch;
    assign second_port_pin_out          = second_if.latch;
    assign third_port_pin_out           = third_if.latch;
    assign first_port_pin_oe_out        = first_if.dir;
    assign second_port_pin_oe_out       = second_if.dir;
    assign third_port_pin_oe_out        = third_dir_q;
    assign first_port_pullup_out        = pullup_q[`NIO_BIT_FIRST_PORT];
    assign second_port_pullup_out       = pullup_q[`NIO_BIT_SECOND_PORT];
    assign third_port_analog_select_out = analog_sel_q;
    assign converter_channel_out        = channel_q;

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Combinational so the core sees the value in the cycle it addresses it
    always_comb
    begin
        core_rdata_out = 4'h0;
        if (mem_hit)
        begin
            case (core_addr_in)
                `NIO_ADDR_FIRST_PORT:  core_rdata_out = first_if.rd_data;
                `NIO_ADDR_SECOND_PORT: core_rdata_out = second_if.rd_data;
                `NIO_ADDR_THIRD_PORT:  core_rdata_out = third_if.rd_data;
                default:               core_rdata_out = 4'h0;
            endcase
        end
        else if (rf_hit)
        begin
            case (core_addr_in)
                `NIO_RF_GROUP_DIR:  core_rdata_out = {2'h0, group_dir_q};
                `NIO_RF_PULLUP:     core_rdata_out = {2'h0, pullup_q};
                `NIO_RF_THIRD_DIR:  core_rdata_out = third_dir_q;
                `NIO_RF_ANALOG_SEL: core_rdata_out = analog_sel_q;
                `NIO_RF_CHANNEL:    core_rdata_out = {2'h0, channel_q};
                default:            core_rdata_out = 4'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic seen_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            seen_q <= 1'b0;
        end
        else
        begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_reset_clears_all: assert property (
        !seen_q |-> (first_port_pin_oe_out == 4'h0) && (second_port_pin_oe_out == 4'h0)
            && (third_port_pin_oe_out == 4'h0) && (third_port_analog_select_out == 4'h0)
            && !first_port_pullup_out && !second_port_pullup_out
            && (first_port_pin_out == 4'h0) && (second_port_pin_out == 4'h0)
            && (third_port_pin_out == 4'h0)
            && (converter_channel_out == 2'h0))
        else $error("state not cleared after reset");

    a_group_dir_write: assert property (
        (wr_rf && core_addr_in == `NIO_RF_GROUP_DIR) |=>
            (first_port_pin_oe_out == {4{$past(core_wdata_in[0])}})
            && (second_port_pin_oe_out == {4{$past(core_wdata_in[1])}}))
        else $error("group direction not taken from write");

    a_pullup_write: assert property (
        (wr_rf && core_addr_in == `NIO_RF_PULLUP) |=>
            (first_port_pullup_out == $past(core_wdata_in[0]))
            && (second_port_pullup_out == $past(core_wdata_in[1])))
        else $error("pull-up bits not taken from write");

    a_latch_input_write: assert property (
        (wr_mem && core_addr_in == `NIO_ADDR_FIRST_PORT && first_port_pin_oe_out == 4'h0)
            |=> first_port_pin_out == $past(core_wdata_in))
        else $error("first latch missed write in input mode");

    a_second_latch_write: assert property (
        (wr_mem && core_addr_in == `NIO_ADDR_SECOND_PORT) ##1 !core_wr_in
            |=> second_port_pin_out == $past(core_wdata_in, 2))
        else $error("second latch lost its write");

    a_group_read_latch: assert property (
        (mem_hit && core_addr_in == `NIO_ADDR_SECOND_PORT && second_port_pin_oe_out[0])
            |-> core_rdata_out == second_port_pin_out)
        else $error("output-mode read not from latch");

    a_third_dir_sel: assert property (
        (wr_rf && core_addr_in == `NIO_RF_THIRD_DIR) ##1 !wr_rf [*2]
            |-> third_port_pin_oe_out == $past(core_wdata_in, 2))
        else $error("third port direction not held from write");

    a_third_read_mix: assert property (
        (mem_hit && core_addr_in == `NIO_ADDR_THIRD_PORT) |->
            ((core_rdata_out ^ third_port_pin_out)
                & (third_port_analog_select_out | third_port_pin_oe_out)) == 4'h0)
        else $error("third port read ignores analog or direction");

    a_third_latch_write: assert property (
        (wr_mem && core_addr_in == `NIO_ADDR_THIRD_PORT) |=>
            third_port_pin_out == $past(core_wdata_in))
        else $error("third latch missed write");

    a_channel_write: assert property (
        (wr_rf && core_addr_in == `NIO_RF_CHANNEL) |=>
            converter_channel_out == $past(core_wdata_in[1:0]))
        else $error("channel select not taken from write");

    a_unmapped_zero: assert property (
        (!mem_hit && !rf_hit) |-> core_rdata_out == 4'h0)
        else $error("read outside bank zero not zero");

    c_first_output: cover property (
        (wr_rf && core_addr_in == `NIO_RF_GROUP_DIR && core_wdata_in[0]) ##1
            (mem_hit && core_addr_in == `NIO_ADDR_FIRST_PORT));
    c_analog_pin: cover property (
        ((third_port_analog_select_out & ~third_port_pin_oe_out) != 4'h0)
            && mem_hit && core_addr_in == `NIO_ADDR_THIRD_PORT);
    c_input_then_drive: cover property (
        (wr_mem && core_addr_in == `NIO_ADDR_SECOND_PORT) ##[1:4]
            (wr_rf && core_addr_in == `NIO_RF_GROUP_DIR && core_wdata_in[1]));

endmodule : nibble_io_ports

`default_nettype wire

/* hdl/nibble_port_slice.sv */
// One port: output latch, pin synchroniser and read-back selector.
// Assumes pin levels are asynchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none

module nibble_port_slice #(
    parameter int WIDTH = 4
) (
    input  wire logic   ref_clk_in,
    input  wire logic   rst_n_in,
    port_slice_if.slice io
);

    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] sync3_q;
    logic [WIDTH-1:0] pin_q;
    logic [WIDTH-1:0] pin_d;

    // ------------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------------
    always_comb
    begin
        latch_d = latch_q;
        if (io.wr_stb)
        begin
            latch_d = io.wr_data;
        end
        pin_d = pin_q;
        for (int i = 0; i < WIDTH; i++)
        begin
            // A level change counts only once the last two stages agree
            if (sync2_q[i] == sync3_q[i])
            begin
                pin_d[i] = sync3_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            latch_q <= '0;
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pin_q   <= '0;
        end
        else
        begin
            latch_q <= latch_d;
            sync1_q <= io.pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q   <= pin_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            // Pin level only for a digital input bit, the latch otherwise
            io.rd_data[i] = (!io.dir[i] && !io.analog_sel[i]) ? pin_q[i] : latch_q[i];
        end
    end

    assign io.latch = latch_q;

endmodule : nibble_port_slice

`default_nettype wire

/* hdl/port_slice_if.sv */
// Carrier between the port top and one port slice.
// Assumes the top drives controls and the slice drives latch and read data.
`timescale 1ns/1ps
`default_nettype none

interface port_slice_if #(parameter int WIDTH = 4);

    logic             wr_stb;
    logic [WIDTH-1:0] wr_data;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] analog_sel;
    logic [WIDTH-1:0] pin_raw;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] rd_data;

    modport ctrl
    (
        output wr_stb,
        output wr_data,
        output dir,
        output analog_sel,
        output pin_raw,
        input  latch,
        input  rd_data
    );

    modport slice
    (
        input  wr_stb,
        input  wr_data,
        input  dir,
        input  analog_sel,
        input  pin_raw,
        output latch,
        output rd_data
    );

endinterface : port_slice_if

`default_nettype wire
